// file: core/rcg_pkg.sv
// rcg_pkg: constants, register map and carrier types of the remote io command gate.
// assumes a single pclk domain; all remote pins are asynchronous to it.
package rcg_pkg;
	// register byte offsets
	localparam logic [11:0] RCG_OFS_CTRL = 12'h000;
	localparam logic [11:0] RCG_OFS_STATE = 12'h004;
	localparam logic [11:0] RCG_OFS_EVENTS = 12'h008;
	localparam logic [11:0] RCG_OFS_CAPTURE = 12'h00c;
	localparam logic [11:0] RCG_OFS_PINS = 12'h010;
	localparam logic [11:0] RCG_OFS_UNIT0 = 12'h080;
	localparam int RCG_UNIT_IDX_LSB = 2;
	localparam int RCG_UNIT_IDX_W = 5;
	localparam int RCG_NUM_UNITS = 32;
	// ctrl fields
	localparam int RCG_CTRL_ASSIGNED = 0;
	localparam int RCG_CTRL_SRC_REMOTE = 1;
	localparam int RCG_CTRL_LP_PAUSE = 2;
	localparam logic [2:0] RCG_CTRL_RESET = 3'h0;
	// state register reset value (ready, running, paused, error, estop, guard, teach)
	localparam logic [6:0] RCG_STATE_RESET = 7'h00;
	// capture fields
	localparam int RCG_CAP_PROG_LSB = 0;
	localparam int RCG_CAP_CMDUNIT_LSB = 8;
	localparam int RCG_CAP_SHOWUNIT_LSB = 16;
	localparam int RCG_CAP_LOWPWR = 24;
	// synchroniser depth
	localparam int RCG_SYNC_STAGES = 3;
	localparam int RCG_PROG_W = 6;
	localparam int RCG_UNIT_W = 5;
	localparam logic [4:0] RCG_UNIT_ALL = 5'h00;

	typedef struct packed {
		logic start;
		logic stop;
		logic pause;
		logic resume;
		logic reset;
		logic low_power;
		logic unit_show;
		logic motors_enable_cmd;
		logic motors_disable_cmd;
		logic [5:0] program_select;
		logic [4:0] unit_select;
	} rcg_pins_t;
	localparam int RCG_PINS_W = $bits(rcg_pins_t);

	typedef struct packed {
		logic start;
		logic stop;
		logic pause;
		logic resume;
		logic reset;
		logic motors_on;
		logic unit_show;
		logic lp_stop;
		logic lp_pause;
	} rcg_evt_t;
	localparam int RCG_EVT_W = $bits(rcg_evt_t);

	typedef struct packed {
		logic ready;
		logic running;
		logic paused;
		logic error;
		logic emergency_stop_active;
		logic guard_open_flag;
		logic manual_teach_flag;
	} rcg_state_t;

	typedef struct packed {
		logic motors_energised;
		logic parked_flag;
		logic high_power_flag;
		logic calibration_needed;
	} rcg_unit_t;

	typedef struct packed {
		logic remote_active;
		rcg_state_t st;
		rcg_unit_t unit;
	} rcg_stat_t;
endpackage

// file: core/rcg_sync.sv
// rcg_sync: three-stage synchroniser with agreement filter and rising-edge pulse per bit.
// assumes asynchronous inputs; outputs are in the pclk domain.
`timescale 1ns/10ps
module rcg_sync import rcg_pkg::*; #(
	parameter int W = RCG_PINS_W
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [W-1:0] pin, // raw asynchronous inputs
	output logic [W-1:0] level, // filtered level
	output logic [W-1:0] rise // one-cycle pulse on accepted rising change
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					level[i] <= 1'b0;
					rise[i] <= 1'b0;
				end else begin
					s1_q[i] <= pin[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					// a change only counts once the last two stages agree
					if (s2_q[i] == s3_q[i]) begin
						level[i] <= s3_q[i];
					end
					rise[i] <= (s2_q[i] == s3_q[i]) && s3_q[i] && !level[i];
				end
			end
		end
	endgenerate
endmodule

// file: core/rcg_top.sv
// rcg_top: remote io command gate; filters remote command pins, checks acceptance and
// reports status pins. software reaches control, state and unit tables over apb.
// assumes the controller firmware keeps state and unit registers current.
`timescale 1ns/10ps
module rcg_top import rcg_pkg::*; (
	input wire logic pclk, // 25 MHz system clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire rcg_pins_t rio_in, // remote command pins from host
	output rcg_stat_t rio_out, // remote status pins to host
	output rcg_evt_t cmd_evt, // accepted command pulses to the controller
	output logic [5:0] main_number, // function number taken at start
	output logic [4:0] target_unit, // robot number taken at motors enable
	output logic low_power_force // forced low power level
);
	rcg_pins_t lvl;
	rcg_pins_t rise;
	logic [RCG_PINS_W-1:0] lvl_v;
	logic [RCG_PINS_W-1:0] rise_v;

	rcg_sync #(.W(RCG_PINS_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(rio_in),
		.level(lvl_v),
		.rise(rise_v)
	);
	assign lvl = rcg_pins_t'(lvl_v);
	assign rise = rcg_pins_t'(rise_v);

	// registers
	logic [2:0] ctrl_q;
	rcg_state_t state_q;
	rcg_evt_t evt_sticky_q;
	rcg_evt_t evt_d;
	rcg_unit_t unit_mem [RCG_NUM_UNITS];
	logic [4:0] show_unit_q;
	logic [5:0] prog_q;
	logic [4:0] cmd_unit_q;
	logic remote_active;

	// apb slave: answer one cycle into the access phase so read data comes from a flop
	logic acc;
	logic done;
	logic wr;
	logic [11:0] a;
	logic unit_hit;
	logic [4:0] unit_idx;
	logic mapped;
	logic [31:0] rd_d;
	assign acc = psel && penable;
	assign done = acc && pready;
	assign wr = done && pwrite;
	assign a = paddr;
	assign unit_hit = (a[11:7] == RCG_OFS_UNIT0[11:7]) && (a[1:0] == 2'b00);
	assign unit_idx = a[RCG_UNIT_IDX_LSB +: RCG_UNIT_IDX_W];
	assign mapped = unit_hit || (a == RCG_OFS_CTRL) || (a == RCG_OFS_STATE)
		|| (a == RCG_OFS_EVENTS) || (a == RCG_OFS_CAPTURE) || (a == RCG_OFS_PINS);

	always_comb begin
		rd_d = 32'h0000_0000;
		if (unit_hit) begin
			rd_d[3:0] = unit_mem[unit_idx];
		end else begin
			case (a)
				RCG_OFS_CTRL: rd_d[2:0] = ctrl_q;
				RCG_OFS_STATE: rd_d[6:0] = state_q;
				RCG_OFS_EVENTS: rd_d[RCG_EVT_W-1:0] = evt_sticky_q;
				RCG_OFS_CAPTURE: begin
					rd_d[RCG_CAP_PROG_LSB +: RCG_PROG_W] = prog_q;
					rd_d[RCG_CAP_CMDUNIT_LSB +: RCG_UNIT_W] = cmd_unit_q;
					rd_d[RCG_CAP_SHOWUNIT_LSB +: RCG_UNIT_W] = show_unit_q;
					rd_d[RCG_CAP_LOWPWR] = lvl.low_power;
				end
				RCG_OFS_PINS: rd_d[RCG_PINS_W-1:0] = lvl_v;
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc && !pready;
			if (acc && !pready) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= !mapped;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= RCG_CTRL_RESET;
			state_q <= RCG_STATE_RESET;
		end else if (wr && a == RCG_OFS_CTRL) begin
			ctrl_q <= pwdata[2:0];
		end else if (wr && a == RCG_OFS_STATE) begin
			state_q <= pwdata[6:0];
		end
	end

	// unit table holds only data, so it needs no reset
	always_ff @(posedge pclk) begin
		if (wr && unit_hit) begin
			unit_mem[unit_idx] <= pwdata[3:0];
		end
	end

	// acceptance
	assign remote_active = ctrl_q[RCG_CTRL_ASSIGNED] && ctrl_q[RCG_CTRL_SRC_REMOTE];
	logic gate; // remote active and not in teach
	logic gate_ne; // additionally no pending error
	logic clear_run;
	assign gate = remote_active && !state_q.manual_teach_flag;
	assign gate_ne = gate && !state_q.error;
	assign clear_run = state_q.ready && !state_q.error && !state_q.emergency_stop_active
		&& !state_q.guard_open_flag;

	always_comb begin
		evt_d = '0;
		evt_d.start = rise.start && gate_ne && clear_run && !lvl.pause && !lvl.stop;
		evt_d.stop = rise.stop && gate_ne;
		evt_d.pause = rise.pause && gate_ne && state_q.running;
		evt_d.resume = rise.resume && gate_ne && state_q.paused && !lvl.pause
			&& !lvl.stop;
		evt_d.reset = rise.reset && gate && state_q.ready;
		evt_d.motors_on = rise.motors_enable_cmd && gate_ne && state_q.ready
			&& !state_q.emergency_stop_active && !state_q.guard_open_flag
			&& !lvl.motors_disable_cmd;
		evt_d.unit_show = rise.unit_show && gate_ne;
		// forced low power is honoured even without remote active
		evt_d.lp_stop = rise.low_power && !ctrl_q[RCG_CTRL_LP_PAUSE];
		evt_d.lp_pause = rise.low_power && ctrl_q[RCG_CTRL_LP_PAUSE];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_evt <= '0;
		end else begin
			cmd_evt <= evt_d;
		end
	end

	// sticky copy for software; a new event wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_sticky_q <= '0;
		end else if (wr && a == RCG_OFS_EVENTS) begin
			evt_sticky_q <= (evt_sticky_q & ~rcg_evt_t'(pwdata[RCG_EVT_W-1:0])) | evt_d;
		end else begin
			evt_sticky_q <= evt_sticky_q | evt_d;
		end
	end

	// function number is the weighted sum of the select bits, zero being the base one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_q <= 6'h00;
		end else if (evt_d.start) begin
			prog_q <= lvl.program_select;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_unit_q <= RCG_UNIT_ALL;
		end else if (evt_d.motors_on) begin
			cmd_unit_q <= lvl.unit_select;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			show_unit_q <= RCG_UNIT_ALL;
		end else if (evt_d.unit_show) begin
			show_unit_q <= lvl.unit_select;
		end
	end

	// unit zero shows the union of robots 1 to 31; unit table entry 0 is left out
	rcg_unit_t shown;
	always_comb begin
		shown = '0;
		if (show_unit_q == RCG_UNIT_ALL) begin
			for (int k = 1; k < RCG_NUM_UNITS; k++) begin
				shown = shown | unit_mem[k];
			end
		end else begin
			shown = unit_mem[show_unit_q];
		end
		if (lvl.low_power) begin
			shown.high_power_flag = 1'b0;
		end
	end

	// status pins follow state in every mode, teach included
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rio_out <= '0;
		end else begin
			rio_out.remote_active <= remote_active;
			rio_out.st <= state_q;
			rio_out.unit <= shown;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_number <= 6'h00;
			target_unit <= RCG_UNIT_ALL;
			low_power_force <= 1'b0;
		end else begin
			main_number <= prog_q;
			target_unit <= cmd_unit_q;
			low_power_force <= lvl.low_power;
		end
	end

	// checks
	sequence s_teach_held;
		state_q.manual_teach_flag [*2];
	endsequence

	property p_teach_blocks;
		@(posedge pclk) disable iff (!presetn)
		s_teach_held |-> (cmd_evt.start || cmd_evt.stop || cmd_evt.pause || cmd_evt.resume
			|| cmd_evt.reset || cmd_evt.motors_on || cmd_evt.unit_show) == 1'b0;
	endproperty
	a_teach_blocks: assert property (p_teach_blocks) else $error("command passed in teach");

	property p_teach_out;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_q.manual_teach_flag) |=> rio_out.st.manual_teach_flag;
	endproperty
	a_teach_out: assert property (p_teach_out) else $error("teach flag not shown");

	property p_remote_active;
		@(posedge pclk) disable iff (!presetn)
		rio_out.remote_active |-> $past(ctrl_q[RCG_CTRL_ASSIGNED] && ctrl_q[RCG_CTRL_SRC_REMOTE]);
	endproperty
	a_remote_active: assert property (p_remote_active) else $error("remote active wrong");

	sequence s_start_edge;
		rise.start && gate_ne && clear_run && !lvl.pause && !lvl.stop;
	endsequence

	property p_start_fires;
		@(posedge pclk) disable iff (!presetn)
		s_start_edge |=> cmd_evt.start ##1 (main_number == $past(prog_q, 1));
	endproperty
	a_start_fires: assert property (p_start_fires) else $error("start not taken");

	property p_error_blocks;
		@(posedge pclk) disable iff (!presetn)
		$past(state_q.error) |-> !(cmd_evt.start || cmd_evt.stop || cmd_evt.pause
			|| cmd_evt.resume || cmd_evt.motors_on);
	endproperty
	a_error_blocks: assert property (p_error_blocks) else $error("command during error");

	property p_pause_running;
		@(posedge pclk) disable iff (!presetn)
		cmd_evt.pause |-> $past(state_q.running);
	endproperty
	a_pause_running: assert property (p_pause_running) else $error("pause not running");

	property p_resume_cond;
		@(posedge pclk) disable iff (!presetn)
		cmd_evt.resume |-> $past(state_q.paused && !lvl.pause && !lvl.stop);
	endproperty
	a_resume_cond: assert property (p_resume_cond) else $error("resume condition");

	property p_motors_cond;
		@(posedge pclk) disable iff (!presetn)
		cmd_evt.motors_on |-> $past(state_q.ready && !lvl.motors_disable_cmd && remote_active);
	endproperty
	a_motors_cond: assert property (p_motors_cond) else $error("motors enable condition");

	property p_lowpower_any;
		@(posedge pclk) disable iff (!presetn)
		rise.low_power |=> (cmd_evt.lp_stop || cmd_evt.lp_pause) ##1 !rio_out.unit.high_power_flag;
	endproperty
	a_lowpower_any: assert property (p_lowpower_any) else $error("low power missed");

	property p_remote_needed;
		@(posedge pclk) disable iff (!presetn)
		!$past(remote_active) |-> !(cmd_evt.stop || cmd_evt.reset || cmd_evt.unit_show);
	endproperty
	a_remote_needed: assert property (p_remote_needed) else $error("command without remote");

	property p_stop_fires;
		@(posedge pclk) disable iff (!presetn)
		rise.stop && remote_active && !state_q.manual_teach_flag && !state_q.error
			|=> cmd_evt.stop;
	endproperty
	a_stop_fires: assert property (p_stop_fires) else $error("stop not taken");

	property p_reset_cond;
		@(posedge pclk) disable iff (!presetn)
		cmd_evt.reset |-> $past(state_q.ready && remote_active && !state_q.manual_teach_flag);
	endproperty
	a_reset_cond: assert property (p_reset_cond) else $error("reset condition");

	property p_prog_capture;
		@(posedge pclk) disable iff (!presetn)
		cmd_evt.start |-> (prog_q == $past(lvl.program_select));
	endproperty
	a_prog_capture: assert property (p_prog_capture) else $error("program number");

	property p_unit_shown;
		@(posedge pclk) disable iff (!presetn)
		(show_unit_q != RCG_UNIT_ALL) && !lvl.low_power
			|=> (rio_out.unit == $past(unit_mem[show_unit_q]));
	endproperty
	a_unit_shown: assert property (p_unit_shown) else $error("unit status wrong");

	property p_lp_select;
		@(posedge pclk) disable iff (!presetn)
		rise.low_power && ctrl_q[RCG_CTRL_LP_PAUSE] |=> cmd_evt.lp_pause && !cmd_evt.lp_stop;
	endproperty
	a_lp_select: assert property (p_lp_select) else $error("low power action");
endmodule

// file: test/rcg_host.sv
// rcg_host: behavioural host controller that drives the remote command pins.
// assumes the bench calls its tasks; pins change only just after rising edges.
`timescale 1ns/10ps
module rcg_host import rcg_pkg::*; (
	input wire logic pclk, // system clock
	input wire rcg_stat_t rio_out, // status pins from the device
	output rcg_pins_t rio_in // command pins to the device
);
	rcg_pins_t lvl;
	int late;
	initial begin
		late = 0;
		lvl = '0;
		rio_in = '0;
	end
	// steady levels; a rising bit here is a command in its own right
	task automatic hold(input rcg_pins_t v);
		@(posedge pclk);
		lvl = v;
		rio_in <= v;
		repeat (8) @(posedge pclk);
	endtask
	// gate low presses regardless, so that refusal can be exercised
	task automatic press(input rcg_pins_t m, input bit gate);
		int n;
		n = 0;
		while (gate && !(rio_out.remote_active === 1'b1 && rio_out.st.ready === 1'b1) && n < 200) begin
			@(posedge pclk);
			n++;
		end
		// a wait that runs out is reported to the bench as a mismatch
		if (gate && n >= 200) begin
			late++;
		end
		@(posedge pclk);
		rio_in <= lvl | m;
		repeat (8) @(posedge pclk);
		rio_in <= lvl;
		// low long enough for the filter to see a release before the next rise
		repeat (8) @(posedge pclk);
	endtask
	task automatic recover();
		if (rio_out.st.error === 1'b1) begin
			press(20'h08000, 1'b1);
		end
	endtask
endmodule

// file: test/rcg_top_tb.sv
// rcg_top_tb: self-checking bench; apb master, host pin model and event scoreboard.
// assumes rcg_top answers apb with one wait state and pulses cmd_evt five edges after a pin.
`timescale 1ns/10ps
module rcg_top_tb;
	import rcg_pkg::*;
	typedef struct packed {
		rcg_evt_t e;
		logic [5:0] n;
	} rcg_exp_t;
	localparam rcg_pins_t P_START = 20'h80000;
	localparam rcg_pins_t P_STOP = 20'h40000;
	localparam rcg_pins_t P_PAUSE = 20'h20000;
	localparam rcg_pins_t P_RES = 20'h10000;
	localparam rcg_pins_t P_LP = 20'h04000;
	localparam rcg_pins_t P_SHOW = 20'h02000;
	localparam rcg_pins_t P_MEN = 20'h01000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_power_force, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, ce;
	logic [5:0] main_number;
	logic [4:0] target_unit;
	logic [15:0] seed;
	rcg_pins_t rio_in, v;
	rcg_stat_t rio_out;
	rcg_evt_t cmd_evt;
	rcg_exp_t q[$];
	rcg_exp_t x;
	int fails, check_count;
	rcg_top u_rcg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rio_in(rio_in), .rio_out(rio_out), .cmd_evt(cmd_evt),
		.main_number(main_number), .target_unit(target_unit), .low_power_force(low_power_force));
	rcg_host u_rcg_host (.pclk(pclk), .rio_out(rio_out), .rio_in(rio_in));
	always #20 pclk = ~pclk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			$display("ERROR at %0t: apb answer timed out", $time);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk(32'(er), 32'(ee));
	endtask
	task automatic st(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (3) @(posedge pclk);
	endtask
	task automatic ex(input rcg_evt_t e, input logic [5:0] n);
		q.push_back({e, n});
	endtask
	task automatic pr(input rcg_pins_t m, input bit g);
		u_rcg_host.press(m, g);
	endtask
	task automatic tend(input string s);
		chk(32'(q.size()), 32'h0);
		chk(32'(u_rcg_host.late), 32'h0);
		q.delete();
		$display("test %s done", s);
	endtask
	// scoreboard: every pulse must match the oldest note
	always @(posedge pclk) begin
		if (presetn === 1'b1 && cmd_evt !== 9'h000) begin
			if (q.size() == 0) begin
				fails++;
				$display("ERROR at %0t: unexpected event %h", $time, cmd_evt);
			end else begin
				x = q.pop_front();
				chk(32'(cmd_evt), 32'(x.e));
				@(posedge pclk);
				if (x.e.start) chk(32'(main_number), 32'(x.n));
				if (x.e.motors_on) chk(32'(target_unit), 32'(x.n[4:0]));
			end
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		$display("ERROR at %0t: watchdog expired", $time);
		test_done();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		fails = 0;
		check_count = 0;
		seed = 16'h2401;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'(rio_out), 32'h0);
		rdchk(RCG_OFS_CTRL, 32'(RCG_CTRL_RESET), 1'b0);
		rdchk(RCG_OFS_STATE, 32'(RCG_STATE_RESET), 1'b0);
		rdchk(12'h040, 32'h0, 1'b1);
		st(RCG_OFS_CTRL, 32'h1);
		chk(32'(rio_out.remote_active), 32'h0);
		st(RCG_OFS_CTRL, 32'h2);
		chk(32'(rio_out.remote_active), 32'h0);
		st(RCG_OFS_CTRL, 32'h3);
		chk(32'(rio_out.remote_active), 32'h1);
		for (int n = 0; n < RCG_NUM_UNITS; n++) begin
			apb(1'b1, RCG_OFS_UNIT0 + 12'(4 * n), (n == 1) ? 32'h1 : (n == 2) ? 32'ha : 32'h0);
		end
		tend("reset");
		st(RCG_OFS_STATE, 32'h41);
		chk(32'(rio_out.st.manual_teach_flag), 32'h1);
		pr(P_START, 1'b1);
		pr(P_SHOW, 1'b1);
		st(RCG_OFS_STATE, 32'h61);
		chk(32'(rio_out.st.running), 32'h1);
		tend("teach");
		st(RCG_OFS_STATE, 32'h40);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = u_rcg_host.lvl;
			v.program_select = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h3f : seed[5:0];
			u_rcg_host.hold(v);
			ex(9'h100, v.program_select);
			pr(P_START, 1'b1);
		end
		u_rcg_host.hold(v | P_PAUSE);
		pr(P_START, 1'b1);
		u_rcg_host.hold(v);
		tend("start");
		st(RCG_OFS_STATE, 32'h08);
		pr(20'h08000, 1'b0);
		st(RCG_OFS_STATE, 32'h48);
		pr(P_START, 1'b1);
		pr(P_STOP, 1'b1);
		ex(9'h010, 6'h00);
		u_rcg_host.recover();
		tend("error");
		st(RCG_OFS_STATE, 32'h00);
		ex(9'h080, 6'h00);
		pr(P_STOP, 1'b0);
		st(RCG_OFS_STATE, 32'h60);
		ex(9'h040, 6'h00);
		pr(P_PAUSE, 1'b1);
		st(RCG_OFS_STATE, 32'h40);
		pr(P_PAUSE, 1'b1);
		st(RCG_OFS_STATE, 32'h50);
		ex(9'h020, 6'h00);
		pr(P_RES, 1'b1);
		u_rcg_host.hold(v | P_PAUSE);
		pr(P_RES, 1'b1);
		u_rcg_host.hold(v);
		tend("stop pause resume");
		st(RCG_OFS_STATE, 32'h40);
		v.unit_select = 5'h05;
		u_rcg_host.hold(v);
		ex(9'h008, 6'h05);
		pr(P_MEN, 1'b1);
		st(RCG_OFS_STATE, 32'h44);
		pr(P_MEN, 1'b1);
		st(RCG_OFS_STATE, 32'h40);
		u_rcg_host.hold(v | 20'h00800);
		pr(P_MEN, 1'b1);
		v.unit_select = 5'h02;
		u_rcg_host.hold(v);
		ex(9'h004, 6'h00);
		pr(P_SHOW, 1'b1);
		chk(32'(rio_out.unit), 32'ha);
		v.unit_select = RCG_UNIT_ALL;
		u_rcg_host.hold(v);
		ex(9'h004, 6'h00);
		pr(P_SHOW, 1'b1);
		chk(32'(rio_out.unit), 32'hb);
		rdchk(RCG_OFS_UNIT0 + 12'h008, 32'ha, 1'b0);
		ce = (32'(v.program_select) << RCG_CAP_PROG_LSB) | (32'h5 << RCG_CAP_CMDUNIT_LSB);
		rdchk(RCG_OFS_CAPTURE, ce, 1'b0);
		rdchk(RCG_OFS_PINS, 32'(v), 1'b0);
		rdchk(RCG_OFS_EVENTS, 32'h1fc, 1'b0);
		st(RCG_OFS_EVENTS, 32'h1ff);
		rdchk(RCG_OFS_EVENTS, 32'h0, 1'b0);
		tend("motors unit");
		st(RCG_OFS_CTRL, 32'h0);
		pr(P_START, 1'b0);
		ex(9'h002, 6'h00);
		u_rcg_host.hold(v | P_LP);
		chk(32'(low_power_force), 32'h1);
		chk(32'(rio_out.unit.high_power_flag), 32'h0);
		u_rcg_host.hold(v);
		st(RCG_OFS_CTRL, 32'h4);
		ex(9'h001, 6'h00);
		u_rcg_host.hold(v | P_LP);
		chk(32'(low_power_force), 32'h1);
		u_rcg_host.hold(v);
		rdchk(RCG_OFS_EVENTS, 32'h003, 1'b0);
		tend("low power");
		test_done();
	end
endmodule
